// ### hdl/flags_register_control.sv
// flags register with carry, direction, transfer, stack and irq enable ops
`timescale 1ns/1ps
`default_nettype none
module flags_register_control
  import flags_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [5:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic maskable_irq_pin,
  output logic irq_service
);

  logic [63:0] flag_word;
  logic [63:0] next_flag_word;
  logic [7:0] accum_high_byte;
  logic [7:0] next_accum_high_byte;
  logic [63:0] pop_image;
  logic [63:0] next_pop_image;
  logic [63:0] push_image;
  logic [63:0] next_push_image;
  logic [3:0] ctrl;
  logic [3:0] next_ctrl;
  logic [31:0] source_index_reg;
  logic [31:0] next_source_index_reg;
  logic [31:0] dest_index_reg;
  logic [31:0] next_dest_index_reg;
  logic refused;
  logic next_refused;
  logic [31:0] next_readdata;
  logic next_waitrequest;
  logic irq_meta;
  logic irq_sync;
  logic next_irq_service;

  logic do_write;
  logic do_cmd;
  op_type op;
  logic [1:0] step_size;
  logic [31:0] stepped_src;
  logic [31:0] stepped_dst;
  logic long_mode;
  logic [1:0] current_priv_level;

  // byte-lane merge for the pop image and index registers
  function automatic logic [31:0] lane_merge(
    input logic [31:0] cur,
    input logic [31:0] wd,
    input logic [3:0] be
  );
    logic [31:0] res;
    res = cur;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[8*i +: 8] = wd[8*i +: 8];
      end
    end
    lane_merge = res;
  endfunction : lane_merge

  // privilege gated pop of a stack image into the flags
  function automatic logic [63:0] pop_merge(
    input logic [63:0] cur,
    input logic [63:0] img,
    input logic full,
    input logic [1:0] priv
  );
    logic [63:0] m;
    logic [1:0] io_lvl;
    io_lvl = cur[IO_PRIV_LO +: 2];
    m = POP_WORD_MASK;
    if (priv == 2'h0) begin
      m = m | IO_PRIV_MASK;
    end
    if (io_lvl >= priv) begin
      m = m | IF_MASK;
    end
    if (full) begin
      m = m | POP_FULL_EXTRA;
    end
    pop_merge = (cur & ~m) | (img & m);
  endfunction : pop_merge

  assign long_mode = ctrl[CTRL_LONG_BIT];
  assign current_priv_level = ctrl[CTRL_PRIV_LO +: 2];
  assign do_write = write && !waitrequest;
  assign do_cmd = do_write && (address == ADDR_CMD) && byteenable[0];
  assign op = op_type'(writedata[CMD_OP_LO +: 4]);
  assign step_size = writedata[CMD_SIZE_LO +: 2];

  index_stepper u_step (
    .src_in(source_index_reg),
    .dst_in(dest_index_reg),
    .direction(flag_word[DIR]),
    .size_log2(step_size),
    .src_out(stepped_src),
    .dst_out(stepped_dst)
  );

  always_comb begin
    next_flag_word = flag_word;
    next_accum_high_byte = accum_high_byte;
    next_pop_image = pop_image;
    next_push_image = push_image;
    next_ctrl = ctrl;
    next_source_index_reg = source_index_reg;
    next_dest_index_reg = dest_index_reg;
    next_refused = refused;
    if (do_write && address == ADDR_STATUS && byteenable[0] &&
        writedata[ST_REFUSED_BIT]) begin
      next_refused = 1'b0;
    end
    if (do_write) begin
      case (address)
        ADDR_ACCUM: begin
          if (byteenable[0]) begin
            next_accum_high_byte = writedata[7:0];
          end
        end
        ADDR_POP_LO: begin
          next_pop_image[31:0] = lane_merge(pop_image[31:0], writedata,
                                            byteenable);
        end
        ADDR_POP_HI: begin
          next_pop_image[63:32] = lane_merge(pop_image[63:32], writedata,
                                             byteenable);
        end
        ADDR_CTRL: begin
          if (byteenable[0]) begin
            next_ctrl = writedata[3:0];
          end
        end
        ADDR_SRC: begin
          next_source_index_reg = lane_merge(source_index_reg, writedata,
                                             byteenable);
        end
        ADDR_DST: begin
          next_dest_index_reg = lane_merge(dest_index_reg, writedata,
                                           byteenable);
        end
        default: begin
        end
      endcase
    end
    // every op lands at the accepting edge, so the next one sees it
    if (do_cmd) begin
      case (op)
        OP_SET_CARRY: next_flag_word[CARRY] = 1'b1;
        OP_CLEAR_CARRY: next_flag_word[CARRY] = 1'b0;
        OP_FLIP_CARRY: next_flag_word[CARRY] = !flag_word[CARRY];
        OP_SET_DIR: next_flag_word[DIR] = 1'b1;
        OP_CLEAR_DIR: next_flag_word[DIR] = 1'b0;
        OP_FLAGS_TO_HB: begin
          if (long_mode && !ctrl[CTRL_FEATURE_BIT]) begin
            next_refused = 1'b1;
          end else begin
            next_accum_high_byte[HB_SIGN] = flag_word[SIGN];
            next_accum_high_byte[HB_ZERO] = flag_word[ZERO];
            next_accum_high_byte[HB_HALF] = flag_word[HALF_CARRY];
            next_accum_high_byte[HB_PARITY] = flag_word[PARITY];
            next_accum_high_byte[HB_CARRY] = flag_word[CARRY];
          end
        end
        OP_HB_TO_FLAGS: begin
          if (long_mode && !ctrl[CTRL_FEATURE_BIT]) begin
            next_refused = 1'b1;
          end else begin
            next_flag_word[SIGN] = accum_high_byte[HB_SIGN];
            next_flag_word[ZERO] = accum_high_byte[HB_ZERO];
            next_flag_word[HALF_CARRY] = accum_high_byte[HB_HALF];
            next_flag_word[PARITY] = accum_high_byte[HB_PARITY];
            next_flag_word[CARRY] = accum_high_byte[HB_CARRY];
          end
        end
        OP_PUSH_WORD: begin
          next_push_image = {48'h0000_0000_0000, flag_word[15:0]};
        end
        OP_PUSH_FULL: begin
          if (long_mode) begin
            next_push_image = flag_word & ~PUSH_HIDE_MASK;
          end else begin
            next_push_image = {32'h0000_0000, flag_word[31:0] &
                               ~PUSH_HIDE_MASK[31:0]};
          end
        end
        OP_POP_WORD: begin
          // same in both modes, upper image bits lie outside the mask
          next_flag_word = pop_merge(flag_word, pop_image, 1'b0,
                                     current_priv_level);
        end
        OP_POP_FULL: begin
          next_flag_word = pop_merge(flag_word, pop_image, 1'b1,
                                     current_priv_level);
          if (long_mode) begin
            next_flag_word[63:32] = 32'h0000_0000;
          end
        end
        OP_SET_IRQ_EN: next_flag_word[IF_BIT] = 1'b1;
        OP_CLEAR_IRQ_EN: next_flag_word[IF_BIT] = 1'b0;
        OP_STRING_STEP: begin
          next_source_index_reg = stepped_src;
          next_dest_index_reg = stepped_dst;
        end
        default: begin
        end
      endcase
    end
    next_flag_word[FIXED_ONE_BIT] = 1'b1;
  end

  // avalon slave: one wait cycle, then a single low waitrequest cycle
  always_comb begin
    next_waitrequest = 1'b1;
    next_readdata = readdata;
    if ((read || write) && waitrequest) begin
      next_waitrequest = 1'b0;
      next_readdata = 32'h0000_0000;
      if (read) begin
        case (address)
          ADDR_FLAGS_LO: next_readdata = flag_word[31:0];
          ADDR_FLAGS_HI: next_readdata = flag_word[63:32];
          ADDR_ACCUM: next_readdata = {24'h00_0000, accum_high_byte};
          ADDR_POP_LO: next_readdata = pop_image[31:0];
          ADDR_POP_HI: next_readdata = pop_image[63:32];
          ADDR_PUSH_LO: next_readdata = push_image[31:0];
          ADDR_PUSH_HI: next_readdata = push_image[63:32];
          ADDR_CTRL: next_readdata = {28'h000_0000, ctrl};
          ADDR_SRC: next_readdata = source_index_reg;
          ADDR_DST: next_readdata = dest_index_reg;
          ADDR_STATUS: next_readdata = {30'h0, irq_service, refused};
          default: next_readdata = 32'h0000_0000;
        endcase
      end
    end
  end

  // irq pin is asynchronous, second stage alone feeds the gate
  always_comb begin
    next_irq_service = irq_sync && flag_word[IF_BIT];
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      flag_word <= FLAGS_RESET;
      accum_high_byte <= 8'h00;
      pop_image <= 64'h0000_0000_0000_0000;
      push_image <= 64'h0000_0000_0000_0000;
      ctrl <= CTRL_RESET;
      source_index_reg <= 32'h0000_0000;
      dest_index_reg <= 32'h0000_0000;
      refused <= 1'b0;
      readdata <= 32'h0000_0000;
      waitrequest <= 1'b1;
      irq_meta <= 1'b0;
      irq_sync <= 1'b0;
      irq_service <= 1'b0;
    end else begin
      flag_word <= next_flag_word;
      accum_high_byte <= next_accum_high_byte;
      pop_image <= next_pop_image;
      push_image <= next_push_image;
      ctrl <= next_ctrl;
      source_index_reg <= next_source_index_reg;
      dest_index_reg <= next_dest_index_reg;
      refused <= next_refused;
      readdata <= next_readdata;
      waitrequest <= next_waitrequest;
      irq_meta <= maskable_irq_pin;
      irq_sync <= irq_meta;
      irq_service <= next_irq_service;
    end
  end

  AST_FLIP_CARRY: assert property (@(posedge ref_clk) disable iff (rst)
    do_cmd && op == OP_FLIP_CARRY
      |=> flag_word[CARRY] != $past(flag_word[CARRY])
      && flag_word[63:1] == $past(flag_word[63:1]))
    else $error("flip carry wrong");

  AST_SET_DIR: assert property (@(posedge ref_clk) disable iff (rst)
    do_cmd && (op == OP_SET_DIR || op == OP_CLEAR_DIR)
      |=> flag_word[DIR] == ($past(op) == OP_SET_DIR))
    else $error("direction flag wrong");

  AST_STEP: assert property (@(posedge ref_clk) disable iff (rst)
    do_cmd && op == OP_STRING_STEP && !flag_word[DIR] && step_size == 2'h0
      |=> source_index_reg == $past(source_index_reg) + 32'h0000_0001)
    else $error("ascending step wrong");

  AST_TO_HB: assert property (@(posedge ref_clk) disable iff (rst)
    do_cmd && op == OP_FLAGS_TO_HB && !long_mode
      |=> accum_high_byte[7] == $past(flag_word[SIGN])
      && accum_high_byte[5] == $past(accum_high_byte[5])
      && accum_high_byte[0] == $past(flag_word[CARRY])
      && flag_word == $past(flag_word))
    else $error("flags to high byte wrong");

  AST_FROM_HB: assert property (@(posedge ref_clk) disable iff (rst)
    do_cmd && op == OP_HB_TO_FLAGS && !long_mode
      |=> flag_word[ZERO] == $past(accum_high_byte[6])
      && flag_word[HALF_CARRY] == $past(accum_high_byte[4]))
    else $error("high byte to flags wrong");

  AST_PUSH_FULL: assert property (@(posedge ref_clk) disable iff (rst)
    do_cmd && op == OP_PUSH_FULL |=> push_image[17:16] == 2'h0
      && push_image[15:0] == $past(flag_word[15:0]))
    else $error("full push image wrong");

  AST_PUSH_WORD: assert property (@(posedge ref_clk) disable iff (rst)
    do_cmd && op == OP_PUSH_WORD |=> push_image[63:16] == 48'h0000_0000_0000)
    else $error("word push not 16 bits");

  AST_IO_PRIV_LEVEL_KEEP: assert property (@(posedge ref_clk) disable iff (rst)
    do_cmd && (op == OP_POP_WORD || op == OP_POP_FULL)
      && current_priv_level != 2'h0
      |=> flag_word[13:12] == $past(flag_word[13:12]))
    else $error("io privilege changed above level zero");

  AST_IF_KEEP: assert property (@(posedge ref_clk) disable iff (rst)
    do_cmd && op == OP_POP_WORD
      && flag_word[IO_PRIV_LO +: 2] < current_priv_level
      |=> flag_word[IF_BIT] == $past(flag_word[IF_BIT]))
    else $error("irq enable changed without privilege");

  AST_LONG_POP: assert property (@(posedge ref_clk) disable iff (rst)
    do_cmd && op == OP_POP_FULL && long_mode |=> flag_word[63:32] == 32'h0)
    else $error("upper flags not cleared");

  AST_REFUSE: assert property (@(posedge ref_clk) disable iff (rst)
    do_cmd && op == OP_HB_TO_FLAGS && long_mode && !ctrl[CTRL_FEATURE_BIT]
      |=> refused && flag_word == $past(flag_word))
    else $error("high byte transfer not refused");

  AST_IRQ_MASK: assert property (@(posedge ref_clk) disable iff (rst)
    !flag_word[IF_BIT] |=> !irq_service)
    else $error("irq serviced while masked");

endmodule : flags_register_control
`default_nettype wire

// ### hdl/flags_pkg.sv
// shared constants for the flags register control block
package flags_pkg;

  // register byte offsets on the avalon slave
  localparam logic [5:0] ADDR_CMD = 6'h00;
  localparam logic [5:0] ADDR_FLAGS_LO = 6'h04;
  localparam logic [5:0] ADDR_FLAGS_HI = 6'h08;
  localparam logic [5:0] ADDR_ACCUM = 6'h0C;
  localparam logic [5:0] ADDR_POP_LO = 6'h10;
  localparam logic [5:0] ADDR_POP_HI = 6'h14;
  localparam logic [5:0] ADDR_PUSH_LO = 6'h18;
  localparam logic [5:0] ADDR_PUSH_HI = 6'h1C;
  localparam logic [5:0] ADDR_CTRL = 6'h20;
  localparam logic [5:0] ADDR_SRC = 6'h24;
  localparam logic [5:0] ADDR_DST = 6'h28;
  localparam logic [5:0] ADDR_STATUS = 6'h2C;

  // flag bit positions in the flags word
  localparam int CARRY = 0;
  localparam int FIXED_ONE_BIT = 1;
  localparam int PARITY = 2;
  localparam int HALF_CARRY = 4;
  localparam int ZERO = 6;
  localparam int SIGN = 7;
  localparam int IF_BIT = 9;
  localparam int DIR = 10;
  localparam int IO_PRIV_LO = 12;

  // accumulator high byte positions of the five status flags
  localparam int HB_SIGN = 7;
  localparam int HB_ZERO = 6;
  localparam int HB_HALF = 4;
  localparam int HB_PARITY = 2;
  localparam int HB_CARRY = 0;

  localparam logic [63:0] FLAGS_RESET = 64'h0000_0000_0000_0002;
  localparam logic [63:0] POP_WORD_MASK = 64'h0000_0000_0000_0DD5;
  localparam logic [63:0] IO_PRIV_MASK = 64'h0000_0000_0000_3000;
  localparam logic [63:0] IF_MASK = 64'h0000_0000_0000_0200;
  localparam logic [63:0] POP_FULL_EXTRA = 64'h0000_0000_0024_0000;
  localparam logic [63:0] PUSH_HIDE_MASK = 64'h0000_0000_0003_0000;

  // control register fields
  localparam int CTRL_LONG_BIT = 0;
  localparam int CTRL_PRIV_LO = 1;
  localparam int CTRL_FEATURE_BIT = 3;
  localparam logic [3:0] CTRL_RESET = 4'h0;

  // status register fields
  localparam int ST_REFUSED_BIT = 0;
  localparam int ST_IRQ_BIT = 1;

  // command word fields
  localparam int CMD_OP_LO = 0;
  localparam int CMD_SIZE_LO = 4;

  typedef enum logic [3:0] {
    OP_NONE = 4'h0,
    OP_SET_CARRY = 4'h1,
    OP_CLEAR_CARRY = 4'h2,
    OP_FLIP_CARRY = 4'h3,
    OP_SET_DIR = 4'h4,
    OP_CLEAR_DIR = 4'h5,
    OP_FLAGS_TO_HB = 4'h6,
    OP_HB_TO_FLAGS = 4'h7,
    OP_PUSH_WORD = 4'h8,
    OP_PUSH_FULL = 4'h9,
    OP_POP_WORD = 4'hA,
    OP_POP_FULL = 4'hB,
    OP_SET_IRQ_EN = 4'hC,
    OP_CLEAR_IRQ_EN = 4'hD,
    OP_STRING_STEP = 4'hE
  } op_type;

endpackage : flags_pkg

// ### hdl/index_stepper.sv
// string index stepping for source and destination index registers
`timescale 1ns/1ps
`default_nettype none
module index_stepper (
  input wire logic [31:0] src_in,
  input wire logic [31:0] dst_in,
  input wire logic direction,
  input wire logic [1:0] size_log2,
  output logic [31:0] src_out,
  output logic [31:0] dst_out
);
  logic [31:0] stride;

  always_comb begin
    stride = 32'h0000_0001 << size_log2;
    if (direction) begin
      src_out = src_in - stride;
      dst_out = dst_in - stride;
    end else begin
      src_out = src_in + stride;
      dst_out = dst_in + stride;
    end
  end
endmodule : index_stepper
`default_nettype wire

// ### sim/pipeline_model.sv
// behavioural pipeline model acting as master on the register port
`timescale 1ns/1ps
`default_nettype none
module pipeline_model (
  input wire logic ref_clk,
  input wire logic waitrequest,
  input wire logic [31:0] readdata,
  output var logic [5:0] address,
  output var logic read,
  output var logic write,
  output var logic [31:0] writedata,
  output var logic [3:0] byteenable
);
  initial begin
    address = 6'h3F;
    read = 1'b0;
    write = 1'b0;
    writedata = 32'h0;
    byteenable = 4'hF;
  end

  // request held until the edge that samples waitrequest low
  task automatic bus_cycle(input logic [5:0] a, input logic wr,
                           input logic [31:0] d, output logic [31:0] q,
                           output logic hung);
    int n;
    n = 0;
    hung = 1'b1;
    q = 32'h0;
    @(posedge ref_clk);
    address <= a;
    writedata <= d;
    byteenable <= 4'hF;
    read <= !wr;
    write <= wr;
    while (n < 20 && hung) begin
      @(posedge ref_clk);
      n++;
      if (waitrequest === 1'b0) begin
        hung = 1'b0;
        q = readdata;
      end
    end
    read <= 1'b0;
    write <= 1'b0;
    // released lines show inverted junk, not the last value
    address <= ~a;
    writedata <= ~d;
  endtask : bus_cycle
endmodule : pipeline_model
`default_nettype wire

// ### sim/testbench.sv
// self-checking bench for the flags register control block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import flags_pkg::*;
  logic ref_clk;
  logic rst;
  logic [5:0] address;
  logic read;
  logic write;
  logic [31:0] writedata;
  logic [3:0] byteenable;
  logic [31:0] readdata;
  logic waitrequest;
  logic maskable_irq_pin;
  logic irq_service;
  int fails;
  int n_checks;
  logic [31:0] c_op [8] = '{32'h1, 32'h3, 32'h3, 32'h2,
                            32'h4, 32'h5, 32'hC, 32'hD};
  logic [31:0] c_exp [8] = '{32'h3, 32'h2, 32'h3, 32'h2,
                             32'h402, 32'h2, 32'h202, 32'h2};

  flags_register_control i_dut (
    .ref_clk(ref_clk), .rst(rst), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable),
    .readdata(readdata), .waitrequest(waitrequest),
    .maskable_irq_pin(maskable_irq_pin), .irq_service(irq_service)
  );

  pipeline_model i_master (
    .ref_clk(ref_clk), .waitrequest(waitrequest), .readdata(readdata),
    .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable)
  );

  always #20 ref_clk = ~ref_clk;

  task automatic wrap_up();
    if (fails == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : wrap_up

  task automatic check32(input string what, input logic [31:0] exp,
                         input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : check32

  task automatic access(input logic [5:0] a, input logic wr,
                        input logic [31:0] d, output logic [31:0] q);
    logic h;
    i_master.bus_cycle(a, wr, d, q, h);
    if (h) begin
      fails++;
      $display("mismatch waitrequest expected 0 seen 1");
      wrap_up();
    end
  endtask : access

  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] q;
    access(a, 1'b1, d, q);
  endtask : wr

  task automatic rdc(input string what, input logic [5:0] a,
                     input logic [31:0] exp);
    logic [31:0] q;
    access(a, 1'b0, 32'h0, q);
    check32(what, exp, q);
  endtask : rdc

  task automatic irq_check(input logic exp);
    // sampled at the edge, before the design's own update lands
    repeat (6) @(posedge ref_clk);
    check32("irq_service", {31'h0, exp}, {31'h0, irq_service});
  endtask : irq_check

  initial begin
    ref_clk = 1'b0;
    rst = 1'b1;
    maskable_irq_pin = 1'b0;
    fails = 0;
    n_checks = 0;
    repeat (16) @(posedge ref_clk);
    rst <= 1'b0;
    rdc("flags_lo", ADDR_FLAGS_LO, FLAGS_RESET[31:0]);
    rdc("flags_hi", ADDR_FLAGS_HI, 32'h0);
    rdc("ctrl", ADDR_CTRL, 32'h0);
    rdc("status", ADDR_STATUS, 32'h0);
    rdc("unmapped", 6'h30, 32'h0);
    // back-to-back op and read, no settling gap
    for (int i = 0; i < 8; i++) begin
      wr(ADDR_CMD, c_op[i]);
      rdc("flags_lo", ADDR_FLAGS_LO, c_exp[i]);
    end
    wr(ADDR_SRC, 32'h100);
    wr(ADDR_DST, 32'h200);
    wr(ADDR_CMD, 32'h2E);
    rdc("src", ADDR_SRC, 32'h104);
    rdc("dst", ADDR_DST, 32'h204);
    wr(ADDR_CMD, 32'h4);
    wr(ADDR_CMD, 32'h0E);
    rdc("src", ADDR_SRC, 32'h103);
    wr(ADDR_CMD, 32'h1E);
    rdc("dst", ADDR_DST, 32'h201);
    wr(ADDR_CMD, 32'h5);
    wr(ADDR_ACCUM, 32'hD5);
    wr(ADDR_CMD, 32'h7);
    rdc("flags_lo", ADDR_FLAGS_LO, 32'hD7);
    wr(ADDR_ACCUM, 32'h2A);
    wr(ADDR_CMD, 32'h6);
    rdc("accum", ADDR_ACCUM, 32'hFF);
    rdc("flags_lo", ADDR_FLAGS_LO, 32'hD7);
    wr(ADDR_ACCUM, 32'h0);
    wr(ADDR_CMD, 32'h7);
    wr(ADDR_ACCUM, 32'hFF);
    wr(ADDR_CMD, 32'h6);
    rdc("accum", ADDR_ACCUM, 32'h2A);
    wr(ADDR_POP_LO, 32'hFFFF_FFFF);
    wr(ADDR_POP_HI, 32'hFFFF_FFFF);
    wr(ADDR_CMD, 32'hA);
    rdc("flags_lo", ADDR_FLAGS_LO, 32'h3FD7);
    wr(ADDR_CMD, 32'hB);
    rdc("flags_lo", ADDR_FLAGS_LO, 32'h243FD7);
    wr(ADDR_CMD, 32'h8);
    rdc("push_lo", ADDR_PUSH_LO, 32'h3FD7);
    rdc("push_hi", ADDR_PUSH_HI, 32'h0);
    wr(ADDR_CMD, 32'h9);
    rdc("push_lo", ADDR_PUSH_LO, 32'h243FD7);
    // privilege three: io level kept, irq enable follows
    wr(ADDR_CTRL, 32'h6);
    wr(ADDR_POP_LO, 32'h0);
    wr(ADDR_POP_HI, 32'h0);
    wr(ADDR_CMD, 32'hA);
    rdc("flags_lo", ADDR_FLAGS_LO, 32'h243002);
    wr(ADDR_CMD, 32'hB);
    rdc("flags_lo", ADDR_FLAGS_LO, 32'h3002);
    wr(ADDR_CMD, 32'hC);
    wr(ADDR_CTRL, 32'h0);
    wr(ADDR_POP_LO, 32'h1200);
    wr(ADDR_CMD, 32'hA);
    rdc("flags_lo", ADDR_FLAGS_LO, 32'h1202);
    wr(ADDR_CTRL, 32'h4);
    wr(ADDR_POP_LO, 32'h0);
    wr(ADDR_CMD, 32'hA);
    rdc("flags_lo", ADDR_FLAGS_LO, 32'h1202);
    wr(ADDR_CTRL, 32'h2);
    wr(ADDR_CMD, 32'hA);
    rdc("flags_lo", ADDR_FLAGS_LO, 32'h1002);
    @(posedge ref_clk);
    maskable_irq_pin <= 1'b1;
    irq_check(1'b0);
    wr(ADDR_CMD, 32'hC);
    irq_check(1'b1);
    rdc("status", ADDR_STATUS, 32'h2);
    wr(ADDR_CMD, 32'hD);
    irq_check(1'b0);
    maskable_irq_pin <= 1'b0;
    // wide mode without the feature bit refuses byte transfers
    wr(ADDR_CTRL, 32'h1);
    wr(ADDR_ACCUM, 32'h5A);
    wr(ADDR_CMD, 32'h6);
    rdc("accum", ADDR_ACCUM, 32'h5A);
    rdc("status", ADDR_STATUS, 32'h1);
    wr(ADDR_CMD, 32'h7);
    rdc("flags_lo", ADDR_FLAGS_LO, 32'h1002);
    wr(ADDR_STATUS, 32'h1);
    rdc("status", ADDR_STATUS, 32'h0);
    wr(ADDR_CTRL, 32'h9);
    wr(ADDR_CMD, 32'h7);
    rdc("flags_lo", ADDR_FLAGS_LO, 32'h1052);
    wr(ADDR_POP_LO, 32'hFFFF_FFFF);
    wr(ADDR_POP_HI, 32'hFFFF_FFFF);
    wr(ADDR_CMD, 32'hB);
    rdc("flags_lo", ADDR_FLAGS_LO, 32'h243FD7);
    rdc("flags_hi", ADDR_FLAGS_HI, 32'h0);
    wr(ADDR_CMD, 32'h9);
    rdc("push_lo", ADDR_PUSH_LO, 32'h243FD7);
    rdc("push_hi", ADDR_PUSH_HI, 32'h0);
    wr(ADDR_POP_LO, 32'h0);
    wr(ADDR_CMD, 32'hA);
    rdc("flags_lo", ADDR_FLAGS_LO, 32'h240002);
    wr(ADDR_CMD, 32'h8);
    rdc("push_lo", ADDR_PUSH_LO, 32'h2);
    wr(6'h30, 32'hFFFF_FFFF);
    rdc("flags_lo", ADDR_FLAGS_LO, 32'h240002);
    wrap_up();
  end
endmodule : testbench
`default_nettype wire
